// *** lmcl_consts.svh ***
// Register map, field positions, reset values and timing of the line mode block
`ifndef LMCL_CONSTS_SVH
`define LMCL_CONSTS_SVH
`define LMCL_A_MODE 8'h00
`define LMCL_A_CODE 8'h04
`define LMCL_A_CLR0 8'h08
`define LMCL_A_CLR1 8'h0c
`define LMCL_A_CLR2 8'h10
`define LMCL_A_LOSDET 8'h14
`define LMCL_A_LOSREC 8'h18
`define LMCL_A_CMD 8'h1c
`define LMCL_A_ERRCMD 8'h20
`define LMCL_A_IMR 8'h24
`define LMCL_A_TXSTAT 8'h28
`define LMCL_B_STD 0
`define LMCL_B_JSEL 1
`define LMCL_B_DAIS 2
`define LMCL_B_RTM 3
`define LMCL_B_RTM_T1 4
`define LMCL_B_TT0 5
`define LMCL_B_XTM 6
`define LMCL_B_TM 7
`define LMCL_F_XC 1:0
`define LMCL_F_RC 3:2
`define LMCL_B_DRS 4
`define LMCL_B_DIG 5
`define LMCL_B_CMI 6
`define LMCL_B_PRE 7
`define LMCL_B_TX_SOFT_RESET 0
`define LMCL_B_RX_SOFT_RESET 1
`define LMCL_B_ERRCMD 0
`define LMCL_B_S_LOS 0
`define LMCL_B_S_SETTLE 1
`define LMCL_B_S_T1 2
`define LMCL_B_S_J1 3
`define LMCL_B_S_CCMISS 4
`define LMCL_RST_REG 8'h00
`define LMCL_RST_IMR 8'hff
`define LMCL_CC_ALL 8'hff
`define LMCL_SETTLE_NS 20000
`define LMCL_CLK_NS 10
`define LMCL_SETTLE_W 11
`define LMCL_LOS_SHIFT 4
`endif

// *** lmcl_pkg.sv ***
// Types shared by the line mode block modules
package lmcl_pkg;
  `include "lmcl_consts.svh"
  typedef enum logic [2:0] {
    LMCL_AMI = 3'h0, LMCL_AMI_B7 = 3'h1, LMCL_HDB3 = 3'h2, LMCL_B8ZS = 3'h3,
    LMCL_CMI = 3'h4, LMCL_CMI_HDB3 = 3'h5, LMCL_B8ZS_PRE = 3'h6
  } lmcl_code_t;
  typedef enum logic [1:0] {LMCL_E1 = 2'b00, LMCL_SETTLE = 2'b01, LMCL_T1 = 2'b11} lmcl_std_t;
  typedef enum logic {LMCL_SIG = 1'b0, LMCL_LOST = 1'b1} lmcl_los_st_t;
endpackage

// *** lmcl_los_if.sv ***
// Carrier between the register block and the loss of signal supervisor
interface lmcl_los_if;
  logic [7:0] det;
  logic [7:0] rec;
  logic bit_en;
  logic bit_val;
  logic clear;
  logic los;
  modport sup (input det, input rec, input bit_en, input bit_val, input clear, output los);
  modport ctl (output det, output rec, output bit_en, output bit_val, output clear, input los);
endinterface

// *** lmcl_los_sup.sv ***
// Loss of signal supervisor: zero run detection and ones density recovery
`include "lmcl_consts.svh"
module lmcl_los_sup
  import lmcl_pkg::*;
#(
  parameter int CNT_W = 13
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link to the register block
  lmcl_los_if.sup los_if
);
  typedef struct packed {
    lmcl_los_st_t st;
    logic [CNT_W-1:0] zeros;
    logic [CNT_W-1:0] win;
    logic [CNT_W-1:0] ones;
  } lmcl_los_t;
  lmcl_los_t r;
  lmcl_los_t nxt;
  logic [CNT_W-1:0] ival;
  logic [CNT_W-1:0] need;

  assign los_if.los = (r.st == LMCL_LOST);

  always_comb begin
    // Interval is (count + 1) blocks of sixteen line bits
    ival = (CNT_W'(los_if.det) + CNT_W'(1)) << `LMCL_LOS_SHIFT;
    need = CNT_W'(los_if.rec) + CNT_W'(1);
    nxt = r;
    if (los_if.clear) begin
      nxt = '0;
      // A zero run that completes under a soft reset still declares loss
      if (los_if.bit_en && !los_if.bit_val && r.st == LMCL_SIG &&
          r.zeros + CNT_W'(1) == ival) begin
        nxt.st = LMCL_LOST;
      end
    end else if (los_if.bit_en) begin
      case (r.st)
        LMCL_SIG: begin
          if (los_if.bit_val) begin
            nxt.zeros = '0;
          end else if (r.zeros + CNT_W'(1) == ival) begin
            nxt.st = LMCL_LOST;
            nxt.zeros = '0;
            nxt.win = '0;
            nxt.ones = '0;
          end else begin
            nxt.zeros = r.zeros + CNT_W'(1);
          end
        end
        LMCL_LOST: begin
          nxt.ones = r.ones + CNT_W'(los_if.bit_val);
          nxt.win = r.win + CNT_W'(1);
          if (nxt.ones == need) begin
            nxt.st = LMCL_SIG;
            nxt.zeros = '0;
            nxt.win = '0;
            nxt.ones = '0;
          end else if (nxt.win == ival) begin
            // Density too low in this interval, start a fresh one
            nxt.win = '0;
            nxt.ones = '0;
          end
        end
        default: nxt = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end
endmodule

// *** lmcl_line_mode.sv ***
// Line mode configuration, line code selection and loss of signal supervision
// How it works
// - Reset leaves the channel in E1 mode with double frame format.
// - Setting line standard select moves to T1/J1 after at most 20 us settling.
// - In T1/J1, japan variant select set gives J1 operation.
// - AIS insert disable at one suppresses any alarm indication insertion.
// - Receive store free run bit makes the dual elastic store free running.
// - In E1, transmit transparent bit makes the transmit path transparent.
// - Transmit free run bit makes the transmitter free running in both standards.
// - In T1/J1, transparent mode bit puts the channel in transparent operation.
// - E1 offers AMI and HDB3 on analog and digital line interfaces.
// - E1 digital modes also offer CMI, with or without HDB3 precoding.
// - T1/J1 offers AMI, AMI with bit 7 stuffing, B8ZS, precoded B8ZS.
// - Detect count 0A hex declares loss after 176 consecutive zeros.
// - Recover count 15 hex clears loss after 22 ones in the interval.
// - Control registers read back, except status, command and error command.
// - Reset clears both LOS count registers and sets every interrupt mask.
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`include "lmcl_consts.svh"
module lmcl_line_mode
  import lmcl_pkg::*;
#(
  parameter int LOS_CNT_W = 13
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Recovered line bits
  input wire logic line_bit_en,
  input wire logic line_bit,
  // Alarm request from the framing side
  input wire logic ais_request,
  // Line mode controls
  output logic t1_mode,
  output logic j1_mode,
  output logic mode_settling,
  output logic ais_insert,
  output logic rx_store_free_run,
  output logic tx_transparent_e1,
  output logic tx_free_run,
  output logic transparent_mode_t1,
  output logic rail_mode_select,
  output lmcl_code_t tx_line_code,
  output lmcl_code_t rx_line_code,
  output logic [23:0] clear_channel_mask,
  // Supervision and commands
  output logic los,
  output logic tx_soft_reset,
  output logic rx_soft_reset,
  output logic error_counter_command
);
  localparam logic [`LMCL_SETTLE_W-1:0] SETTLE_CYC =
    `LMCL_SETTLE_W'(`LMCL_SETTLE_NS / `LMCL_CLK_NS);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] code;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic [7:0] los_det;
    logic [7:0] los_rec;
    logic [7:0] interrupt_mask_regs;
    lmcl_std_t std;
    logic target_t1;
    logic [`LMCL_SETTLE_W-1:0] settle_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic readyout;
    logic resp;
    logic t1;
    logic j1;
    logic settling;
    logic ais;
    logic rx_free;
    logic tx_tt;
    logic tx_free;
    logic tm;
    logic drs;
    lmcl_code_t txc;
    lmcl_code_t rxc;
    logic [23:0] ccm;
    logic los;
    logic txres;
    logic rxres;
    logic errcmd;
  } lmcl_top_t;

  lmcl_top_t r;
  lmcl_top_t nxt;
  logic acc;
  logic mapped;
  logic [7:0] wd;

  lmcl_los_if los_if ();

  lmcl_los_sup #(
    .CNT_W(LOS_CNT_W)
  ) u_los (
    .hclk(hclk),
    .hresetn(hresetn),
    .los_if(los_if)
  );

  // Selects the effective line code from the standard and the code bits
  function automatic lmcl_code_t lmcl_code_dec(input logic t1, input logic [1:0] fld,
                                               input logic dig, input logic cmi,
                                               input logic pre);
    lmcl_code_t c;
    if (t1) begin
      if (fld[1]) begin
        c = (dig && pre) ? LMCL_B8ZS_PRE : LMCL_B8ZS;
      end else begin
        c = fld[0] ? LMCL_AMI_B7 : LMCL_AMI;
      end
    end else if (dig && cmi) begin
      c = pre ? LMCL_CMI_HDB3 : LMCL_CMI;
    end else begin
      c = fld[1] ? LMCL_HDB3 : LMCL_AMI;
    end
    return c;
  endfunction

  // Read-back word; write-only and unused addresses read zero
  function automatic logic [7:0] lmcl_rd(input lmcl_top_t s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `LMCL_A_MODE: d = s.mode;
      `LMCL_A_CODE: d = s.code;
      `LMCL_A_CLR0: d = s.clr0;
      `LMCL_A_CLR1: d = s.clr1;
      `LMCL_A_CLR2: d = s.clr2;
      `LMCL_A_LOSDET: d = s.los_det;
      `LMCL_A_LOSREC: d = s.los_rec;
      `LMCL_A_IMR: d = s.interrupt_mask_regs;
      `LMCL_A_TXSTAT: begin
        d[`LMCL_B_S_LOS] = s.los;
        d[`LMCL_B_S_SETTLE] = s.settling;
        d[`LMCL_B_S_T1] = s.t1;
        d[`LMCL_B_S_J1] = s.j1;
        d[`LMCL_B_S_CCMISS] = s.t1 && (s.txc == LMCL_AMI || s.rxc == LMCL_AMI) &&
          ((s.clr0 & s.clr1 & s.clr2) != `LMCL_CC_ALL);
      end
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  assign acc = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:8] == 24'h000000);
  assign wd = hwdata[7:0];
  assign los_if.det = r.los_det;
  assign los_if.rec = r.los_rec;
  assign los_if.bit_en = line_bit_en;
  assign los_if.bit_val = line_bit;
  assign los_if.clear = r.rxres;

  always_comb begin
    nxt = r;
    nxt.readyout = 1'b1;
    nxt.resp = 1'b0;
    nxt.txres = 1'b0;
    nxt.rxres = 1'b0;
    nxt.errcmd = 1'b0;
    // Data phase of a write: only the low byte lane carries register data
    if (r.wr_pend) begin
      case (r.wr_addr)
        `LMCL_A_MODE: nxt.mode = wd;
        `LMCL_A_CODE: nxt.code = wd;
        `LMCL_A_CLR0: nxt.clr0 = wd;
        `LMCL_A_CLR1: nxt.clr1 = wd;
        `LMCL_A_CLR2: nxt.clr2 = wd;
        `LMCL_A_LOSDET: nxt.los_det = wd;
        `LMCL_A_LOSREC: nxt.los_rec = wd;
        `LMCL_A_IMR: nxt.interrupt_mask_regs = wd;
        `LMCL_A_CMD: begin
          nxt.txres = wd[`LMCL_B_TX_SOFT_RESET];
          nxt.rxres = wd[`LMCL_B_RX_SOFT_RESET];
        end
        `LMCL_A_ERRCMD: nxt.errcmd = wd[`LMCL_B_ERRCMD];
        default: nxt.errcmd = 1'b0;
      endcase
    end
    nxt.wr_pend = acc && hwrite && mapped;
    nxt.wr_addr = haddr[7:0];
    // Standard change waits for the internal clocking to settle
    case (r.std)
      LMCL_E1: begin
        if (r.mode[`LMCL_B_STD]) begin
          nxt.std = LMCL_SETTLE;
          nxt.target_t1 = 1'b1;
          nxt.settle_cnt = SETTLE_CYC - `LMCL_SETTLE_W'(1);
        end
      end
      LMCL_T1: begin
        if (!r.mode[`LMCL_B_STD]) begin
          nxt.std = LMCL_SETTLE;
          nxt.target_t1 = 1'b0;
          nxt.settle_cnt = SETTLE_CYC - `LMCL_SETTLE_W'(1);
        end
      end
      LMCL_SETTLE: begin
        if (r.mode[`LMCL_B_STD] != r.target_t1) begin
          // Host changed its mind mid-settle: restart toward the new target
          nxt.target_t1 = r.mode[`LMCL_B_STD];
          nxt.settle_cnt = SETTLE_CYC - `LMCL_SETTLE_W'(1);
        end else if (r.settle_cnt == '0) begin
          nxt.std = r.target_t1 ? LMCL_T1 : LMCL_E1;
        end else begin
          nxt.settle_cnt = r.settle_cnt - `LMCL_SETTLE_W'(1);
        end
      end
      default: nxt.std = LMCL_E1;
    endcase
    // The old standard stays in force until settling is over
    if (nxt.std == LMCL_T1) begin
      nxt.t1 = 1'b1;
    end else if (nxt.std == LMCL_E1) begin
      nxt.t1 = 1'b0;
    end
    nxt.settling = (nxt.std == LMCL_SETTLE);
    nxt.j1 = nxt.t1 && nxt.mode[`LMCL_B_JSEL];
    nxt.ais = ais_request && !nxt.mode[`LMCL_B_DAIS];
    nxt.rx_free = nxt.t1 ? nxt.mode[`LMCL_B_RTM_T1] : nxt.mode[`LMCL_B_RTM];
    nxt.tx_tt = !nxt.t1 && nxt.mode[`LMCL_B_TT0];
    nxt.tx_free = nxt.mode[`LMCL_B_XTM];
    nxt.tm = nxt.t1 && nxt.mode[`LMCL_B_TM];
    nxt.drs = nxt.code[`LMCL_B_DRS];
    nxt.txc = lmcl_code_dec(nxt.t1, nxt.code[`LMCL_F_XC], nxt.code[`LMCL_B_DIG],
                            nxt.code[`LMCL_B_CMI], nxt.code[`LMCL_B_PRE]);
    nxt.rxc = lmcl_code_dec(nxt.t1, nxt.code[`LMCL_F_RC], nxt.code[`LMCL_B_DIG],
                            nxt.code[`LMCL_B_CMI], nxt.code[`LMCL_B_PRE]);
    nxt.ccm = {nxt.clr2, nxt.clr1, nxt.clr0};
    nxt.los = los_if.los;
    // Read data taken from the updated state, so a write followed by a read
    // of the same register returns the new value
    if (acc && !hwrite) begin
      nxt.rdata = mapped ? {24'h000000, lmcl_rd(nxt, haddr[7:0])} : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.mode <= `LMCL_RST_REG;
      r.code <= `LMCL_RST_REG;
      r.los_det <= `LMCL_RST_REG;
      r.los_rec <= `LMCL_RST_REG;
      r.interrupt_mask_regs <= `LMCL_RST_IMR;
      r.readyout <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  assign hreadyout = r.readyout;
  assign hrdata = r.rdata;
  assign hresp = r.resp;
  assign t1_mode = r.t1;
  assign j1_mode = r.j1;
  assign mode_settling = r.settling;
  assign ais_insert = r.ais;
  assign rx_store_free_run = r.rx_free;
  assign tx_transparent_e1 = r.tx_tt;
  assign tx_free_run = r.tx_free;
  assign transparent_mode_t1 = r.tm;
  assign rail_mode_select = r.drs;
  assign tx_line_code = r.txc;
  assign rx_line_code = r.rxc;
  assign clear_channel_mask = r.ccm;
  assign los = r.los;
  assign tx_soft_reset = r.txres;
  assign rx_soft_reset = r.rxres;
  assign error_counter_command = r.errcmd;
endmodule

// *** lmcl_line_mode_properties.sv ***
// Concurrent checks on the line mode block ports
`include "lmcl_consts.svh"
module lmcl_line_mode_properties (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Line and alarm inputs
  input wire logic line_bit_en,
  input wire logic line_bit,
  input wire logic ais_request,
  // Watched outputs
  input wire logic t1_mode,
  input wire logic j1_mode,
  input wire logic mode_settling,
  input wire logic ais_insert,
  input wire logic los,
  input wire logic rx_soft_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Settling budget in clock cycles; a counter keeps the property cheap
  localparam int SETTLE_LIM = `LMCL_SETTLE_NS / `LMCL_CLK_NS;
  int settle_run;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_run <= 0;
    end else if (mode_settling) begin
      settle_run <= settle_run + 1;
    end else begin
      settle_run <= 0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_reset_e1;
    $rose(hresetn) |-> !t1_mode && !mode_settling && !los;
  endproperty
  a_reset_e1: assert property (p_reset_e1) else $error("not E1 after reset");
  property p_settle_bound;
    mode_settling |-> settle_run <= SETTLE_LIM;
  endproperty
  a_settle_bound: assert property (p_settle_bound) else $error("settling too long");
  property p_std_via_settle;
    $changed(t1_mode) |-> $past(mode_settling);
  endproperty
  a_std_via_settle: assert property (p_std_via_settle) else $error("standard jumped");
  property p_j1_in_t1;
    j1_mode |-> t1_mode;
  endproperty
  a_j1_in_t1: assert property (p_j1_in_t1) else $error("j1 without t1");
  property p_ais_cause;
    ais_insert |-> $past(ais_request);
  endproperty
  a_ais_cause: assert property (p_ais_cause) else $error("ais without request");
  property p_los_on_zero;
    $rose(los) |-> $past(line_bit_en && !line_bit, 2);
  endproperty
  a_los_on_zero: assert property (p_los_on_zero) else $error("los not after a zero");
  property p_one_restarts;
    line_bit_en && line_bit |-> ##2 !$rose(los);
  endproperty
  a_one_restarts: assert property (p_one_restarts) else $error("los after a one");
  // Soft reset may also clear the alarm, so allow its short latency
  property p_los_clear;
    $fell(los) |-> $past(line_bit_en && line_bit, 2) || $past(rx_soft_reset)
      || $past(rx_soft_reset, 2) || $past(rx_soft_reset, 3);
  endproperty
  a_los_clear: assert property (p_los_clear) else $error("los cleared without ones");
endmodule

// *** lmcl_line_far.sv ***
// Far end line model: one recovered bit per cycle while running
module lmcl_line_far (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench control
  input wire logic run,
  input wire logic mark,
  // Recovered line bits
  output logic line_bit_en,
  output logic line_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle line toggles so a stale bit is never mistaken for data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_bit_en <= 1'b0;
      line_bit <= 1'b0;
    end else begin
      line_bit_en <= run;
      line_bit <= run ? mark : ~line_bit;
    end
  end
endmodule

// *** tb_line_mode_config_los.sv ***
// Self-checking bench for the line mode block
`include "lmcl_consts.svh"
module tb_line_mode_config_los import lmcl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ais_request = 1'b0;
  logic run = 1'b0, mark = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, line_bit_en, line_bit, t1_mode, j1_mode, mode_settling;
  logic ais_insert, rx_store_free_run, tx_transparent_e1, tx_free_run, transparent_mode_t1;
  logic rail_mode_select, los, tx_soft_reset, rx_soft_reset, error_counter_command;
  logic [23:0] clear_channel_mask;
  lmcl_code_t tx_line_code, rx_line_code;
  int n_fail = 0, total_checks = 0, cyc = 0, k;
  logic [7:0] cv [2][4] = '{'{8'h05, 8'h1a, 8'h60, 8'he0}, '{8'h00, 8'h05, 8'h0a, 8'haa}};
  lmcl_code_t ce [2][4] = '{'{LMCL_AMI, LMCL_HDB3, LMCL_CMI, LMCL_CMI_HDB3},
    '{LMCL_AMI, LMCL_AMI_B7, LMCL_B8ZS, LMCL_B8ZS_PRE}};
  assign hready = hreadyout;
  lmcl_line_mode #(.LOS_CNT_W(13)) i_dut (.*);
  lmcl_line_far i_far (.*);
  always #5 hclk = ~hclk;
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard well above the two 2000 cycle standard changes
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, q, e);
    chk("okay", {hreadyout, hresp}, 32'h2);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic send(input int n, input logic v);
    @(posedge hclk);
    run <= 1'b1;
    mark <= v;
    repeat (n) @(posedge hclk);
    run <= 1'b0;
  endtask
  task automatic codes(input int m);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `LMCL_A_CODE, cv[m][i]);
      step(2);
      chk("tx_code", tx_line_code, ce[m][i]);
      chk("rx_code", rx_line_code, ce[m][i]);
      chk("rail", rail_mode_select, cv[m][i][4]);
    end
  endtask
  task automatic settle(input logic t1);
    step(2);
    chk("settling", mode_settling, 1);
    k = 2;
    while (t1_mode !== t1 && k < 2100) begin
      step(1);
      k++;
    end
    chk("settle_time", k > 1995 && k <= 2002, 1);
  endtask
  task automatic pulses(input logic [7:0] a, input logic [7:0] d);
    int c = 0;
    bus(1'b1, a, d);
    // Pulses stand in the cycle right after the data phase ends
    repeat (3) begin
      #1;
      c += tx_soft_reset + 2 * rx_soft_reset + 4 * error_counter_command;
      @(posedge hclk);
    end
    chk("cmd_pulse", c, (a == `LMCL_A_CMD) * (d[0] + 2 * d[1]) +
        4 * (a == `LMCL_A_ERRCMD) * d[0]);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`LMCL_A_MODE, 0, "mode_rst");
    rd(`LMCL_A_LOSDET, 0, "det_rst");
    rd(`LMCL_A_LOSREC, 0, "rec_rst");
    rd(`LMCL_A_IMR, 32'hff, "imr_rst");
    chk("t1_rst", t1_mode, 0);
    bus(1'b1, `LMCL_A_IMR, 8'h5a);
    rd(`LMCL_A_IMR, 32'h5a, "imr_rw");
    bus(1'b1, `LMCL_A_CLR1, 8'h3c);
    rd(`LMCL_A_CLR1, 32'h3c, "clr1_rw");
    bus(1'b1, `LMCL_A_TXSTAT, 8'hff);
    rd(`LMCL_A_TXSTAT, 0, "txstat_ro");
    rd(`LMCL_A_CMD, 0, "cmd_wo");
    rd(8'h40, 0, "unmapped");
    ais_request <= 1'b1;
    step(2);
    chk("ais_on", ais_insert, 1);
    bus(1'b1, `LMCL_A_MODE, 8'h6c);
    step(2);
    chk("ais_off", ais_insert, 0);
    chk("rx_free", rx_store_free_run, 1);
    chk("tx_transp", tx_transparent_e1, 1);
    chk("tx_free", tx_free_run, 1);
    chk("transp_t1", transparent_mode_t1, 0);
    codes(0);
    bus(1'b1, `LMCL_A_LOSDET, 8'h0a);
    bus(1'b1, `LMCL_A_LOSREC, 8'h15);
    send(100, 1'b0);
    send(1, 1'b1);
    send(100, 1'b0);
    step(4);
    chk("los_restart", los, 0);
    send(1, 1'b1);
    send(175, 1'b0);
    step(4);
    chk("los_175", los, 0);
    send(1, 1'b0);
    step(3);
    chk("los_176", los, 1);
    rd(`LMCL_A_TXSTAT, 32'h01, "txstat_los");
    send(21, 1'b1);
    step(3);
    chk("los_21", los, 1);
    send(1, 1'b1);
    step(3);
    chk("los_22", los, 0);
    send(176, 1'b0);
    pulses(`LMCL_A_CMD, 8'h03);
    chk("los_sreset", los, 0);
    pulses(`LMCL_A_ERRCMD, 8'h01);
    bus(1'b1, `LMCL_A_MODE, 8'h6d);
    settle(1'b1);
    bus(1'b1, `LMCL_A_MODE, 8'hd3);
    step(2);
    chk("j1", j1_mode, 1);
    chk("transp_t1_on", transparent_mode_t1, 1);
    chk("rx_free_t1", rx_store_free_run, 1);
    chk("tx_transp_t1", tx_transparent_e1, 0);
    chk("tx_free_t1", tx_free_run, 1);
    codes(1);
    bus(1'b1, `LMCL_A_CODE, 8'h00);
    rd(`LMCL_A_TXSTAT, 32'h1c, "cc_missing");
    bus(1'b1, `LMCL_A_CLR0, 8'hff);
    bus(1'b1, `LMCL_A_CLR1, 8'hff);
    bus(1'b1, `LMCL_A_CLR2, 8'hff);
    rd(`LMCL_A_TXSTAT, 32'h0c, "cc_done");
    chk("cc_mask", clear_channel_mask, 32'hffffff);
    bus(1'b1, `LMCL_A_MODE, 8'h6c);
    settle(1'b0);
    chk("j1_off", j1_mode, 0);
    complete_run();
  end
endmodule
bind lmcl_line_mode lmcl_line_mode_properties i_props (.*);
